/* hdl/pcfg_pkg.sv */
`default_nettype none
package pcfg_pkg;

  typedef logic [31:0] pcfg_word_t;
  typedef logic [9:0]  pcfg_base_t;
  typedef logic [11:0] pcfg_addr_t;
  typedef logic [3:0]  pcfg_be_t;

  // configuration offsets
  localparam pcfg_addr_t OFF_CLASS  = 12'h0408;
  localparam pcfg_addr_t OFF_HDR    = 12'h040c;
  localparam pcfg_addr_t OFF_BAR0   = 12'h0410;
  localparam pcfg_addr_t OFF_BAR1   = 12'h0414;
  localparam pcfg_addr_t OFF_SUBSYS = 12'h042c;

  // class and revision fields
  localparam logic [7:0] BASE_CLASS = 8'h03;
  localparam logic [7:0] SUB_CLASS  = 8'h80;
  localparam logic [7:0] PROG_IF    = 8'h00;
  localparam logic [7:0] REVISION   = 8'h00;  // arbitrary revision value

  // cache line, latency, header type, self-test bytes
  localparam logic [7:0] CACHELINE_VAL = 8'h00;
  localparam logic [7:0] LATENCY_VAL   = 8'h00;
  localparam logic [7:0] HEADER_TYPE   = 8'h00;
  localparam logic [7:0] SELFTEST_VAL  = 8'h00;

  // base address layout
  localparam int         BASE_LSB    = 22;
  localparam int         BASE_MSB    = 31;
  localparam logic [21:0] BAR_LOW_RO = 22'h00_0000;
  localparam pcfg_base_t BASE_RST    = 10'h000;

  // subsystem identity
  localparam pcfg_word_t SUBSYS_RST  = 32'h0000_0100;
  localparam pcfg_word_t WORD_ZERO   = 32'h0000_0000;

  // byte-enable merge of a write into a stored word
  function automatic pcfg_word_t pcfg_merge(input pcfg_word_t old_w,
                                            input pcfg_word_t new_w,
                                            input pcfg_be_t   be);
    pcfg_word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // window match on address bits 31-22
  function automatic logic pcfg_hit(input pcfg_word_t addr,
                                    input pcfg_base_t base);
    return addr[BASE_MSB:BASE_LSB] == base;
  endfunction

endpackage
`default_nettype wire

/* hdl/pcfg_win_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pcfg_win_if;
  import pcfg_pkg::*;
  pcfg_base_t reg_base;
  pcfg_base_t fb_base;
  logic       mem_en;
  logic       req;
  pcfg_word_t addr;
  logic       hit_reg;
  logic       hit_fb;

  modport regs (output reg_base, fb_base, mem_en, req, addr,
                input  hit_reg, hit_fb);
  modport dec  (input  reg_base, fb_base, mem_en, req, addr,
                output hit_reg, hit_fb);
endinterface
`default_nettype wire

/* hdl/pcfg_win_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module pcfg_win_decode (
  pcfg_win_if.dec win
);
  import pcfg_pkg::*;

  wire qualified;

  assign qualified   = win.req & win.mem_en;
  assign win.hit_reg = qualified & pcfg_hit(win.addr, win.reg_base);
  assign win.hit_fb  = qualified & pcfg_hit(win.addr, win.fb_base);

endmodule // pcfg_win_decode
`default_nettype wire

/* hdl/pcfg_regs.sv */
// Behaviour
// - class bits 31-24 read 03 hex, writes ignored
// - class bits 23-16 read 80 hex
// - class bits 15-8 read 00 hex
// - class bits 7-0 read a fixed build-time revision
// - cache line, latency and self-test bytes always read zero
// - header type byte reads 00 hex
// - register window base bits 3-0 read zero
// - register window bits 21-4 read zero, bits 31-22 writable base
// - frame buffer base bits 3-0 read zero
// - frame buffer bits 21-4 read zero, bits 31-22 writable base
// - subsystem vendor id bits 15-0 writable, set by software
// - subsystem id bits 31-16 writable, read back last value
// - memory hits ignored until memory space enable is set
`timescale 1ns/1ns
`default_nettype none
module pcfg_regs (
  // clock and reset
  input  wire  logic                i_ref_clk,
  input  wire  logic                i_rst_b,
  // configuration access
  input  wire  logic                i_cfg_rd,
  input  wire  logic                i_cfg_wr,
  input  wire  pcfg_pkg::pcfg_addr_t i_cfg_addr,
  input  wire  pcfg_pkg::pcfg_be_t  i_cfg_be,
  input  wire  pcfg_pkg::pcfg_word_t i_cfg_wdata,
  output var   pcfg_pkg::pcfg_word_t o_cfg_rdata,
  output var   logic                o_cfg_rvalid,
  // memory access decode
  input  wire  logic                i_mem_space_en,
  input  wire  logic                i_mem_req,
  input  wire  pcfg_pkg::pcfg_word_t i_mem_addr,
  output var   logic                o_reg_win_hit,
  output var   logic                o_fb_win_hit
);
  import pcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  pcfg_base_t reg_base;
  pcfg_base_t fb_base;
  pcfg_word_t subsys;

  pcfg_win_if win ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire sel_class;
  wire sel_hdr;
  wire sel_bar0;
  wire sel_bar1;
  wire sel_subsys;

  assign sel_class  = i_cfg_addr == OFF_CLASS;
  assign sel_hdr    = i_cfg_addr == OFF_HDR;
  assign sel_bar0   = i_cfg_addr == OFF_BAR0;
  assign sel_bar1   = i_cfg_addr == OFF_BAR1;
  assign sel_subsys = i_cfg_addr == OFF_SUBSYS;

  ////////////////////////////////////////////////////////////////////////////
  // read words

  pcfg_word_t class_word;
  pcfg_word_t hdr_word;
  pcfg_word_t bar0_word;
  pcfg_word_t bar1_word;
  pcfg_word_t read_word;

  assign class_word = {BASE_CLASS,
                       SUB_CLASS,
                       PROG_IF,
                       REVISION};
  assign hdr_word   = {SELFTEST_VAL,
                       HEADER_TYPE,
                       LATENCY_VAL,
                       CACHELINE_VAL};
  assign bar0_word  = {reg_base, BAR_LOW_RO};
  assign bar1_word  = {fb_base, BAR_LOW_RO};

  assign read_word = sel_class  ? class_word :
                     sel_hdr    ? hdr_word   :
                     sel_bar0   ? bar0_word  :
                     sel_bar1   ? bar1_word  :
                     sel_subsys ? subsys     :
                     WORD_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // write merge

  pcfg_word_t bar0_merged;
  pcfg_word_t bar1_merged;
  pcfg_word_t subsys_merged;
  pcfg_base_t next_reg_base;
  pcfg_base_t next_fb_base;
  pcfg_word_t next_subsys;

  assign bar0_merged   = pcfg_merge(bar0_word, i_cfg_wdata, i_cfg_be);
  assign bar1_merged   = pcfg_merge(bar1_word, i_cfg_wdata, i_cfg_be);
  assign subsys_merged = pcfg_merge(subsys, i_cfg_wdata, i_cfg_be);

  assign next_reg_base = (i_cfg_wr && sel_bar0) ?
                         bar0_merged[BASE_MSB:BASE_LSB] : reg_base;
  assign next_fb_base  = (i_cfg_wr && sel_bar1) ?
                         bar1_merged[BASE_MSB:BASE_LSB] : fb_base;
  assign next_subsys   = (i_cfg_wr && sel_subsys) ?
                         subsys_merged : subsys;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      reg_base <= BASE_RST;
      fb_base  <= BASE_RST;
      subsys   <= SUBSYS_RST;
    end else begin
      reg_base <= next_reg_base;
      fb_base  <= next_fb_base;
      subsys   <= next_subsys;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata  <= WORD_ZERO;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rdata  <= i_cfg_rd ? read_word : o_cfg_rdata;
      o_cfg_rvalid <= i_cfg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window decode

  assign win.reg_base = reg_base;
  assign win.fb_base  = fb_base;
  assign win.mem_en   = i_mem_space_en;
  assign win.req      = i_mem_req;
  assign win.addr     = i_mem_addr;

  pcfg_win_decode u_decode (
    .win (win.dec)
  );

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_win_hit <= 1'b0;
      o_fb_win_hit  <= 1'b0;
    end else begin
      o_reg_win_hit <= win.hit_reg;
      o_fb_win_hit  <= win.hit_fb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_rd_class;
    i_cfg_rd && sel_class;
  endsequence

  sequence s_rd_hdr;
    i_cfg_rd && sel_hdr;
  endsequence

  sequence s_bar0_full_wr;
    i_cfg_wr && sel_bar0 && (i_cfg_be == 4'hf);
  endsequence

  sequence s_bar1_full_wr;
    i_cfg_wr && sel_bar1 && (i_cfg_be == 4'hf);
  endsequence

  sequence s_subsys_full_wr;
    i_cfg_wr && sel_subsys && (i_cfg_be == 4'hf);
  endsequence

  sequence s_cfg_idle;
    !i_cfg_rd;
  endsequence

  sequence s_fb_match;
    i_mem_req && i_mem_space_en
      && i_mem_addr[BASE_MSB:BASE_LSB] == fb_base;
  endsequence

  sequence s_reg_miss;
    i_mem_req && i_mem_space_en
      && i_mem_addr[BASE_MSB:BASE_LSB] != reg_base;
  endsequence

  class_base_a: assert property (
    s_rd_class |=> o_cfg_rvalid && o_cfg_rdata[31:24] == BASE_CLASS)
    else $error("base class byte wrong");

  class_sub_a: assert property (
    s_rd_class |=> o_cfg_rdata[23:16] == SUB_CLASS)
    else $error("sub class byte wrong");

  class_progif_a: assert property (
    s_rd_class |=> o_cfg_rdata[15:8] == PROG_IF)
    else $error("programming interface byte wrong");

  class_rev_a: assert property (
    s_rd_class |=> o_cfg_rdata[7:0] == REVISION)
    else $error("revision byte wrong");

  hdr_zero_a: assert property (
    s_rd_hdr |=> o_cfg_rvalid && o_cfg_rdata == WORD_ZERO)
    else $error("header word not zero");

  hdr_type_a: assert property (
    s_rd_hdr |=> o_cfg_rdata[23:16] == HEADER_TYPE)
    else $error("header type wrong");

  bar0_low_a: assert property (
    i_cfg_rd && sel_bar0 |=> o_cfg_rdata[21:0] == BAR_LOW_RO)
    else $error("register window low bits not zero");

  bar0_store_a: assert property (
    s_bar0_full_wr ##1 (i_cfg_rd && sel_bar0 && !i_cfg_wr)
      |=> o_cfg_rdata[31:22] == $past(i_cfg_wdata[31:22], 2))
    else $error("register window base not stored");

  bar1_low_a: assert property (
    i_cfg_rd && sel_bar1 |=> o_cfg_rdata[21:0] == BAR_LOW_RO)
    else $error("frame buffer low bits not zero");

  bar1_store_a: assert property (
    s_bar1_full_wr ##1 (i_cfg_rd && sel_bar1 && !i_cfg_wr)
      |=> o_cfg_rdata[31:22] == $past(i_cfg_wdata[31:22], 2))
    else $error("frame buffer base not stored");

  subsys_vid_a: assert property (
    s_subsys_full_wr |=> subsys[15:0] == $past(i_cfg_wdata[15:0]))
    else $error("subsystem vendor id not written");

  subsys_back_a: assert property (
    s_subsys_full_wr ##1 (i_cfg_rd && sel_subsys && !i_cfg_wr)
      |=> o_cfg_rdata == $past(i_cfg_wdata, 2))
    else $error("subsystem id not read back");

  mem_gate_a: assert property (
    !i_mem_space_en |=> !o_reg_win_hit && !o_fb_win_hit)
    else $error("window hit while memory space off");

  be_mask_a: assert property (
    i_cfg_wr && sel_subsys && !i_cfg_be[0]
      |=> subsys[7:0] == $past(subsys[7:0]))
    else $error("disabled byte lane written");

  win_hit_a: assert property (
    i_mem_req && i_mem_space_en
      && i_mem_addr[31:22] == reg_base |=> o_reg_win_hit)
    else $error("register window hit missed");

  fb_hit_a: assert property (
    i_mem_req && i_mem_space_en
      && i_mem_addr[31:22] != fb_base |=> !o_fb_win_hit)
    else $error("false frame buffer hit");

  rd_valid_a: assert property (
    i_cfg_rd |=> o_cfg_rvalid ##1 (o_cfg_rvalid == $past(i_cfg_rd)))
    else $error("read answer missing");

  fb_win_a: assert property (
    s_fb_match |=> o_fb_win_hit)
    else $error("frame buffer window hit missed");

  reg_false_a: assert property (
    s_reg_miss |=> !o_reg_win_hit)
    else $error("false register window hit");

  no_req_a: assert property (
    !i_mem_req |=> !o_reg_win_hit && !o_fb_win_hit)
    else $error("window hit without request");

  rd_quiet_a: assert property (
    s_cfg_idle |=> !o_cfg_rvalid && $stable(o_cfg_rdata))
    else $error("read answer without request");

  unmapped_rd_a: assert property (
    i_cfg_rd && !(sel_class || sel_hdr || sel_bar0 || sel_bar1 || sel_subsys)
      |=> o_cfg_rdata == WORD_ZERO)
    else $error("unmapped offset read not zero");

  fb_be_a: assert property (
    i_cfg_wr && sel_bar1 && !i_cfg_be[3]
      |=> fb_base[9:2] == $past(fb_base[9:2]))
    else $error("frame buffer base upper lane written");

  subsys_be_a: assert property (
    i_cfg_wr && sel_subsys && !i_cfg_be[3]
      |=> subsys[31:24] == $past(subsys[31:24]))
    else $error("subsystem id upper lane written");

  ro_write_a: assert property (
    i_cfg_wr && (sel_class || sel_hdr)
      |=> reg_base == $past(reg_base) && fb_base == $past(fb_base)
          && subsys == $past(subsys))
    else $error("read-only write changed state");

  subsys_keep_a: assert property (
    !(i_cfg_wr && sel_subsys) |=> $stable(subsys))
    else $error("subsystem word changed without write");

endmodule // pcfg_regs
`default_nettype wire

/* sim/pcfg_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pcfg_host_model (
  // clock
  input  wire logic                 i_ref_clk,
  // configuration cycle
  output var  logic                 o_cfg_rd,
  output var  logic                 o_cfg_wr,
  output var  pcfg_pkg::pcfg_addr_t o_cfg_addr,
  output var  pcfg_pkg::pcfg_be_t   o_cfg_be,
  output var  pcfg_pkg::pcfg_word_t o_cfg_wdata,
  // memory cycle
  output var  logic                 o_mem_space_en,
  output var  logic                 o_mem_req,
  output var  pcfg_pkg::pcfg_word_t o_mem_addr
);
  import pcfg_pkg::*;

  initial begin
    o_cfg_rd       = 1'b0;
    o_cfg_wr       = 1'b0;
    o_cfg_addr     = 12'h0000;
    o_cfg_be       = 4'h0;
    o_cfg_wdata    = 32'h0000_0000;
    o_mem_space_en = 1'b0;
    o_mem_req      = 1'b0;
    o_mem_addr     = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // one config cycle, released address and data lines show inverted leftovers
  task automatic cfg(input logic rd, input logic wr, input pcfg_addr_t a,
                     input pcfg_be_t be, input pcfg_word_t d);
    @(posedge i_ref_clk);
    o_cfg_rd    <= rd;
    o_cfg_wr    <= wr;
    o_cfg_addr  <= a;
    o_cfg_be    <= be;
    o_cfg_wdata <= d;
    @(posedge i_ref_clk);
    o_cfg_rd    <= 1'b0;
    o_cfg_wr    <= 1'b0;
    o_cfg_addr  <= ~a;
    o_cfg_wdata <= ~d;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // write then read of one offset on back-to-back edges
  task automatic wr_rd(input pcfg_addr_t a, input pcfg_word_t d);
    @(posedge i_ref_clk);
    o_cfg_wr    <= 1'b1;
    o_cfg_addr  <= a;
    o_cfg_be    <= 4'hf;
    o_cfg_wdata <= d;
    @(posedge i_ref_clk);
    o_cfg_wr    <= 1'b0;
    o_cfg_rd    <= 1'b1;
    o_cfg_wdata <= ~d;
    @(posedge i_ref_clk);
    o_cfg_rd    <= 1'b0;
    o_cfg_addr  <= ~a;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one memory address probe
  task automatic mem(input logic en, input pcfg_word_t a);
    @(posedge i_ref_clk);
    o_mem_space_en <= en;
    o_mem_req      <= 1'b1;
    o_mem_addr     <= a;
    @(posedge i_ref_clk);
    o_mem_req      <= 1'b0;
    o_mem_addr     <= ~a;
    #1;
  endtask
endmodule // pcfg_host_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pcfg_pkg::*;

  logic       i_ref_clk;
  logic       i_rst_b;
  logic       cfg_rd;
  logic       cfg_wr;
  pcfg_addr_t cfg_addr;
  pcfg_be_t   cfg_be;
  pcfg_word_t cfg_wdata;
  pcfg_word_t rdata;
  logic       rvalid;
  logic       mem_en;
  logic       mem_req;
  pcfg_word_t mem_addr;
  logic       reg_hit;
  logic       fb_hit;
  int         err_total;
  int         n_compared;

  pcfg_host_model u_host (.i_ref_clk(i_ref_clk), .o_cfg_rd(cfg_rd),
    .o_cfg_wr(cfg_wr), .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be),
    .o_cfg_wdata(cfg_wdata), .o_mem_space_en(mem_en),
    .o_mem_req(mem_req), .o_mem_addr(mem_addr));

  pcfg_regs DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
    .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .i_mem_space_en(mem_en), .i_mem_req(mem_req),
    .i_mem_addr(mem_addr), .o_reg_win_hit(reg_hit), .o_fb_win_hit(fb_hit));

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input pcfg_word_t got, input pcfg_word_t exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input pcfg_addr_t a, input pcfg_word_t exp);
    u_host.cfg(1'b1, 1'b0, a, 4'hf, 32'h0000_0000);
    chk({31'h0000_0000, rvalid}, 32'h0000_0001);
    chk(rdata, exp);
  endtask

  task automatic wr(input pcfg_addr_t a, input pcfg_be_t be,
                    input pcfg_word_t d);
    u_host.cfg(1'b0, 1'b1, a, be, d);
  endtask

  task automatic probe(input logic en, input pcfg_word_t a,
                       input pcfg_word_t exp);
    u_host.mem(en, a);
    chk({30'h0000_0000, reg_hit, fb_hit}, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values;
    rd(OFF_CLASS, {8'h03, 8'h80, 8'h00, REVISION});
    rd(OFF_HDR, 32'h0000_0000);
    rd(OFF_BAR0, 32'h0000_0000);
    rd(OFF_BAR1, 32'h0000_0000);
    rd(OFF_SUBSYS, 32'h0000_0100);
    rd(12'h0418, 32'h0000_0000);
  endtask

  task automatic t_read_only;
    wr(OFF_CLASS, 4'hf, 32'hffff_ffff);
    wr(OFF_HDR, 4'hf, 32'hffff_ffff);
    rd(OFF_CLASS, {8'h03, 8'h80, 8'h00, REVISION});
    rd(OFF_HDR, 32'h0000_0000);
  endtask

  task automatic t_bars;
    wr(OFF_BAR0, 4'hf, 32'hffff_ffff);
    rd(OFF_BAR0, 32'hffc0_0000);
    wr(OFF_BAR1, 4'h4, 32'hffff_ffff);
    rd(OFF_BAR1, 32'h00c0_0000);
    wr(OFF_BAR1, 4'h8, 32'h5a00_0000);
    rd(OFF_BAR1, 32'h5ac0_0000);
  endtask

  task automatic t_subsys;
    wr(OFF_SUBSYS, 4'h3, 32'h1234_5678);
    rd(OFF_SUBSYS, 32'h0000_5678);
    wr(OFF_SUBSYS, 4'hc, 32'h1234_5678);
    rd(OFF_SUBSYS, 32'h1234_5678);
    u_host.cfg(1'b1, 1'b1, OFF_SUBSYS, 4'hf, 32'habcd_0123);
    chk(rdata, 32'h1234_5678);
    rd(OFF_SUBSYS, 32'habcd_0123);
  endtask

  task automatic t_windows;
    probe(1'b0, 32'hffc0_0010, 32'h0000_0000);
    probe(1'b1, 32'hffc0_0010, 32'h0000_0002);
    probe(1'b1, 32'h5aff_fffc, 32'h0000_0001);
    probe(1'b1, 32'h5a80_0000, 32'h0000_0000);
  endtask

  task automatic t_back_to_back;
    u_host.wr_rd(OFF_BAR0, 32'h8040_0000);
    chk(rdata, 32'h8040_0000);
    u_host.wr_rd(OFF_BAR1, 32'h4000_fff0);
    chk(rdata, 32'h4000_0000);
    u_host.wr_rd(OFF_SUBSYS, 32'hbeef_cafe);
    chk(rdata, 32'hbeef_cafe);
  endtask

  task automatic t_second_reset;
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd(OFF_BAR0, 32'h0000_0000);
    rd(OFF_SUBSYS, 32'h0000_0100);
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock, sequence, watchdog
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    err_total  = 0;
    n_compared = 0;
    i_rst_b    = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_reset_values;
    t_read_only;
    t_bars;
    t_subsys;
    t_windows;
    t_back_to_back;
    t_second_reset;
    report_and_stop;
  end

  initial begin
    repeat (500) @(posedge i_ref_clk);
    err_total++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
